// >>> core/mmuf_top.v
// Data translation fault entry, unified buffer and mapped buffer access
// Functional notes
// - Unified buffer miss raises data miss fault
// - Miss event code 040 read, 060 write
// - Purge/writeback count as read; invalidate/alloc write
// - Protection fail gives 0a0 read, 0c0 write
// - Permitted write to clean page gives 080
// - Load page number and full fault address
// - Save faulting pc, or branch pc in slot
// - Save status and general register 15
// - Set privilege, block and bank status bits
// - Miss branches to vector base plus 400
// - Protection and first write use plus 100
// - Load instruction writes page entries into buffer
// - Refetch bit zero forces refetch after control write
// - Longword only accesses; reserved bits undefined
// - Address array at top byte f2, entry 9:8
// - Data word: page 31:10, valid 8, space 7:0
// - Valid reachable through address and data views; only the address array is mapped here
// - Address array read returns, write stores fields
`timescale 1ns/10ps
`default_nettype none
`include "mmuf_defines.vh"

module mmuf_top (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Data access from the load/store pipeline
  input wire acc_valid,
  input wire [2:0] acc_op,
  input wire [31:0] acc_vaddr,
  input wire [31:0] acc_pc,
  input wire acc_delay_slot,
  input wire [31:0] acc_branch_pc,
  input wire [31:0] gr15,
  // Access result
  output reg acc_done,
  output reg acc_fault,
  output reg [31:0] acc_paddr,
  output reg [31:0] fault_target,
  // Buffer load command and refetch request
  input wire tlb_load,
  output reg refetch_req
);

  // ==========================================================
  // Software visible registers
  reg [31:0] page_entry_high_reg;
  reg [31:0] page_entry_low_reg;
  reg [31:0] fault_address_reg;
  reg [11:0] exception_event_reg;
  reg [31:0] saved_pc_reg;
  reg [31:0] saved_status_reg;
  reg [31:0] saved_stack_reg;
  reg [31:0] status_reg;
  reg [31:0] vector_base_reg;
  reg [31:0] mmu_control_reg;
  reg [31:0] refetch_control_reg;

  // Unified buffer, 64 entries held in flops
  reg [21:0] u_page [0:63];
  reg [7:0] u_space [0:63];
  reg [63:0] u_valid;
  reg [63:0] u_dirty;
  reg [1:0] u_prot [0:63];
  reg [18:0] u_frame [0:63];
  integer i;
  integer j;

  wire [5:0] replacement_counter = mmu_control_reg[`MMUF_CTRL_COUNT_LSB +: 6];

  // ==========================================================
  // Access classification
  function is_write_op;
    input [2:0] op;
    begin
      is_write_op = (op == `MMUF_OP_STORE) || (op == `MMUF_OP_INVAL) ||
                    (op == `MMUF_OP_ALLOC);
    end
  endfunction

  // Protection field: bit1 user allowed, bit0 write allowed
  function prot_allows;
    input [1:0] prot;
    input wr;
    input priv;
    begin
      prot_allows = (priv | prot[1]) & (~wr | prot[0]);
    end
  endfunction

  // ==========================================================
  // Associative lookup over the unified buffer
  reg hit;
  reg [5:0] hit_idx;
  always @* begin
    hit = 1'b0;
    hit_idx = 6'h0;
    for (i = 0; i < 64; i = i + 1) begin
      if (u_valid[i] && u_page[i] == acc_vaddr[31:10] &&
          u_space[i] == page_entry_high_reg[7:0] && !hit) begin
        hit = 1'b1;
        hit_idx = i[5:0];
      end
    end
  end

  // Fault decision in fixed priority, so only one is reported
  wire acc_wr = is_write_op(acc_op);
  wire priv_now = status_reg[`MMUF_STAT_PRIV];
  wire prot_ok = prot_allows(u_prot[hit_idx], acc_wr, priv_now);
  wire f_miss = !hit;
  wire f_prot = hit && !prot_ok;
  wire f_first = hit && prot_ok && acc_wr && !u_dirty[hit_idx];
  wire any_fault = f_miss | f_prot | f_first;
  reg [11:0] next_event;
  always @* begin
    if (f_miss) begin
      next_event = acc_wr ? `MMUF_EVT_MISS_WR : `MMUF_EVT_MISS_RD;
    end else if (f_prot) begin
      next_event = acc_wr ? `MMUF_EVT_PROT_WR : `MMUF_EVT_PROT_RD;
    end else begin
      next_event = `MMUF_EVT_FIRST_WR;
    end
  end
  // Faults taken only while the block bit is clear; else nothing is saved, though acc_fault is still raised
  wire take_fault = acc_valid && any_fault && !status_reg[`MMUF_STAT_BLOCK];

  // ==========================================================
  // APB decode; writes land at the edge that completes the access
  wire apb_access = psel && penable;
  wire apb_done = apb_access && pready;
  wire apb_wr = apb_done && pwrite && !pslverr;
  wire iaddr_hit = paddr[31:24] == `MMUF_IADDR_TAG;
  wire [31:0] iaddr_rd;

  reg [31:0] next_rdata;
  reg next_err;
  always @* begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      next_err = 1'b1;
    end else if (iaddr_hit) begin
      next_rdata = iaddr_rd;
    end else if (paddr == `MMUF_ADDR_PAGE_HIGH) begin
      next_rdata = page_entry_high_reg;
    end else if (paddr == `MMUF_ADDR_PAGE_LOW) begin
      next_rdata = page_entry_low_reg;
    end else if (paddr == `MMUF_ADDR_FAULT_ADDR) begin
      next_rdata = fault_address_reg;
    end else if (paddr == `MMUF_ADDR_EVENT) begin
      next_rdata = {20'h0, exception_event_reg};
    end else if (paddr == `MMUF_ADDR_SAVED_PC) begin
      next_rdata = saved_pc_reg;
    end else if (paddr == `MMUF_ADDR_SAVED_STATUS) begin
      next_rdata = saved_status_reg;
    end else if (paddr == `MMUF_ADDR_SAVED_STACK) begin
      next_rdata = saved_stack_reg;
    end else if (paddr == `MMUF_ADDR_STATUS) begin
      next_rdata = status_reg;
    end else if (paddr == `MMUF_ADDR_VECTOR_BASE) begin
      next_rdata = vector_base_reg;
    end else if (paddr == `MMUF_ADDR_MMU_CTRL) begin
      next_rdata = mmu_control_reg;
    end else if (paddr == `MMUF_ADDR_REFETCH_CTRL) begin
      next_rdata = refetch_control_reg;
    end else begin
      next_err = 1'b1;
    end
  end

  // One wait state so read data and response leave flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access && !pready;
      if (apb_access && !pready) begin
        prdata <= pwrite ? 32'h0 : next_rdata;
        pslverr <= next_err;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  mmuf_iaddr_array u_iaddr (
    .pclk(pclk),
    .presetn(presetn),
    .sel(paddr[9:8]),
    .wr_en(apb_wr && iaddr_hit),
    .wr_data(pwdata),
    .rd_data(iaddr_rd)
  );

  // ==========================================================
  // Control and fault state; a fault wins over a same-cycle write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_entry_high_reg <= 32'h0;
      page_entry_low_reg <= 32'h0;
      fault_address_reg <= 32'h0;
      exception_event_reg <= 12'h0;
      saved_pc_reg <= 32'h0;
      saved_status_reg <= 32'h0;
      saved_stack_reg <= 32'h0;
      status_reg <= `MMUF_STAT_RESET;
      vector_base_reg <= 32'h0;
      mmu_control_reg <= 32'h0;
      refetch_control_reg <= `MMUF_REFETCH_RESET;
    end else begin
      if (apb_wr) begin
        if (paddr == `MMUF_ADDR_PAGE_HIGH) page_entry_high_reg <= pwdata;
        if (paddr == `MMUF_ADDR_PAGE_LOW) page_entry_low_reg <= pwdata;
        if (paddr == `MMUF_ADDR_STATUS) status_reg <= pwdata;
        if (paddr == `MMUF_ADDR_VECTOR_BASE) vector_base_reg <= pwdata;
        if (paddr == `MMUF_ADDR_MMU_CTRL) mmu_control_reg <= pwdata;
        if (paddr == `MMUF_ADDR_REFETCH_CTRL) refetch_control_reg <= pwdata;
      end
      if (take_fault) begin
        page_entry_high_reg <= {acc_vaddr[31:10], 2'h0,
                                page_entry_high_reg[7:0]};
        fault_address_reg <= acc_vaddr;
        exception_event_reg <= next_event;
        saved_pc_reg <= acc_delay_slot ? acc_branch_pc : acc_pc;
        saved_status_reg <= status_reg;
        saved_stack_reg <= gr15;
        status_reg <= status_reg | (32'h1 << `MMUF_STAT_PRIV) |
                      (32'h1 << `MMUF_STAT_BLOCK) |
                      (32'h1 << `MMUF_STAT_BANK);
      end
    end
  end

  // ==========================================================
  // Unified buffer fill from the two page entry registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u_valid <= 64'h0;
      u_dirty <= 64'h0;
      for (j = 0; j < 64; j = j + 1) begin
        u_page[j] <= 22'h0;
        u_space[j] <= 8'h0;
        u_prot[j] <= 2'h0;
        u_frame[j] <= 19'h0;
      end
    end else if (tlb_load) begin
      // Counter is used as given; software keeps it sane
      u_page[replacement_counter] <= page_entry_high_reg[31:10];
      u_space[replacement_counter] <= page_entry_high_reg[7:0];
      u_frame[replacement_counter] <= page_entry_low_reg[28:10];
      u_prot[replacement_counter] <= page_entry_low_reg[`MMUF_LOW_PROT_LSB +: 2];
      u_valid[replacement_counter] <= page_entry_low_reg[`MMUF_LOW_VALID];
      u_dirty[replacement_counter] <= page_entry_low_reg[`MMUF_LOW_DIRTY];
    end
  end

  // ==========================================================
  // Access answer one cycle after the request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done <= 1'b0;
      acc_fault <= 1'b0;
      acc_paddr <= 32'h0;
      fault_target <= 32'h0;
    end else begin
      acc_done <= acc_valid;
      acc_fault <= acc_valid && any_fault;
      if (acc_valid && !any_fault) begin
        acc_paddr <= {3'h0, u_frame[hit_idx], acc_vaddr[9:0]};
      end
      if (take_fault) begin
        fault_target <= vector_base_reg + (f_miss ? `MMUF_VEC_MISS :
                        `MMUF_VEC_GENERAL);
      end
    end
  end

  // ==========================================================
  // Refetch pulse after a control write while the refetch bit is low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refetch_req <= 1'b0;
    end else begin
      refetch_req <= apb_wr && paddr == `MMUF_ADDR_MMU_CTRL &&
                     !refetch_control_reg[`MMUF_REFETCH_BIT];
    end
  end

endmodule

`default_nettype wire

// >>> core/mmuf_defines.vh
// Constants for the data fault entry and translation buffer map block
`ifndef MMUF_DEFINES_VH
`define MMUF_DEFINES_VH

// ==========================================================
// Register byte addresses on the APB
`define MMUF_ADDR_PAGE_HIGH 32'hff00_0000
`define MMUF_ADDR_PAGE_LOW 32'hff00_0004
`define MMUF_ADDR_FAULT_ADDR 32'hff00_0008
`define MMUF_ADDR_EVENT 32'hff00_000c
`define MMUF_ADDR_SAVED_PC 32'hff00_0010
`define MMUF_ADDR_SAVED_STATUS 32'hff00_0014
`define MMUF_ADDR_SAVED_STACK 32'hff00_0018
`define MMUF_ADDR_STATUS 32'hff00_001c
`define MMUF_ADDR_VECTOR_BASE 32'hff00_0020
`define MMUF_ADDR_MMU_CTRL 32'hff00_0024
`define MMUF_ADDR_REFETCH_CTRL 32'hff00_0028
`define MMUF_IADDR_TAG 8'hf2

// ==========================================================
// Event codes and vector offsets
`define MMUF_EVT_MISS_RD 12'h040
`define MMUF_EVT_MISS_WR 12'h060
`define MMUF_EVT_PROT_RD 12'h0a0
`define MMUF_EVT_PROT_WR 12'h0c0
`define MMUF_EVT_FIRST_WR 12'h080
`define MMUF_VEC_MISS 32'h0000_0400
`define MMUF_VEC_GENERAL 32'h0000_0100

// ==========================================================
// Field positions
`define MMUF_STAT_PRIV 30
`define MMUF_STAT_BANK 29
`define MMUF_STAT_BLOCK 28
`define MMUF_CTRL_COUNT_LSB 10
`define MMUF_CTRL_BOUND_LSB 18
`define MMUF_LOW_VALID 8
`define MMUF_LOW_PROT_LSB 5
`define MMUF_LOW_DIRTY 2
`define MMUF_REFETCH_BIT 0

// ==========================================================
// Reset values
`define MMUF_STAT_RESET 32'h7000_0000
`define MMUF_REFETCH_RESET 32'h0000_0000

// ==========================================================
// Access kinds from the load/store pipeline
`define MMUF_OP_LOAD 3'h0
`define MMUF_OP_STORE 3'h1
`define MMUF_OP_PURGE 3'h2
`define MMUF_OP_WBACK 3'h3
`define MMUF_OP_INVAL 3'h4
`define MMUF_OP_ALLOC 3'h5

`endif

// >>> core/mmuf_instr_xlate_buffer_addr.v
// Instruction translation buffer address array, four entries
`timescale 1ns/10ps
`default_nettype none

module mmuf_iaddr_array (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Access port
  input wire [1:0] sel,
  input wire wr_en,
  input wire [31:0] wr_data,
  output wire [31:0] rd_data
);

  reg [21:0] page_num [0:3];
  reg [3:0] valid;
  reg [7:0] space_id [0:3];
  integer i;

  // ==========================================================
  // Entry storage, cleared to invalid at reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        page_num[i] <= 22'h0;
        space_id[i] <= 8'h0;
      end
    end else if (wr_en) begin
      page_num[sel] <= wr_data[31:10];
      valid[sel] <= wr_data[8];
      space_id[sel] <= wr_data[7:0];
    end
  end

  // Reserved bit 9 reads as zero
  assign rd_data = {page_num[sel], 1'b0, valid[sel], space_id[sel]};

endmodule

`default_nettype wire

// >>> verif/mmuf_chk_assertions.sv
// Port-level checker for the fault entry block
`timescale 1ns/10ps
`default_nettype none
`include "mmuf_defines.vh"

module mmuf_chk (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Access and results
  input wire logic acc_valid,
  input wire logic [31:0] acc_vaddr,
  input wire logic acc_done,
  input wire logic acc_fault,
  input wire logic [31:0] acc_paddr,
  input wire logic [31:0] fault_target,
  input wire logic refetch_req
);
  // ==========================================================
  // Access and bus relations, one clock domain
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  done_after_req_a: assert property (acc_valid |=> acc_done) else $error("no done");
  no_stray_done_a: assert property (!acc_valid |=> !acc_done) else $error("stray done");
  fault_with_done_a: assert property (acc_fault |-> acc_done) else $error("lone fault");
  target_on_fault_a: assert property ($changed(fault_target) |-> acc_fault)
    else $error("target moved");
  hit_offset_a: assert property (acc_done && !acc_fault |->
    acc_paddr[9:0] == $past(acc_vaddr[9:0])) else $error("bad offset");
  one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone error");
  misalign_err_a: assert property (psel && penable && pready && paddr[1:0] != 2'b00
    |-> pslverr) else $error("misaligned taken");
  iaddr_mapped_a: assert property (pready && paddr[31:24] == `MMUF_IADDR_TAG
    && paddr[1:0] == 2'b00 |-> !pslverr) else $error("instr_xlate_buffer refused");
  refetch_cause_a: assert property (refetch_req |->
    $past(psel && penable && pready && pwrite && paddr == `MMUF_ADDR_MMU_CTRL, 1) ||
    $past(psel && penable && pready && pwrite && paddr == `MMUF_ADDR_MMU_CTRL, 2))
    else $error("stray refetch");
endmodule

bind mmuf_top mmuf_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr), .acc_valid(acc_valid),
  .acc_vaddr(acc_vaddr), .acc_done(acc_done), .acc_fault(acc_fault), .acc_paddr(acc_paddr),
  .fault_target(fault_target), .refetch_req(refetch_req));
`default_nettype wire

// >>> verif/mmuf_core_model.sv
// Load/store pipeline model issuing data accesses
`timescale 1ns/10ps
`default_nettype none

module mmuf_core_model (
  // Clock and answer
  input wire logic pclk,
  input wire logic acc_done,
  input wire logic acc_fault,
  // Access request
  output logic acc_valid,
  output logic [2:0] acc_op,
  output logic [31:0] acc_vaddr,
  output logic [31:0] acc_pc,
  output logic [31:0] acc_branch_pc,
  output logic [31:0] gr15,
  output logic acc_delay_slot
);
  logic seen;
  // ==========================================================
  // Idle values at time zero
  initial begin
    acc_valid = 0;
    acc_op = 0;
    acc_vaddr = 0;
    acc_pc = 0;
    acc_branch_pc = 0;
    gr15 = 0;
    acc_delay_slot = 0;
  end
  // One pulse; qualifiers flip after it so stale values never look valid
  task automatic access(input logic [2:0] op, input logic [31:0] va, input logic slot);
    @(posedge pclk);
    acc_valid <= 1;
    acc_op <= op;
    acc_vaddr <= va;
    acc_pc <= va + 32'h10;
    acc_branch_pc <= va + 32'h0c;
    gr15 <= ~va;
    acc_delay_slot <= slot;
    @(posedge pclk);
    acc_valid <= 0;
    acc_vaddr <= ~va;
    gr15 <= va;
    acc_op <= ~op;
    @(posedge pclk);
    seen = acc_fault;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the fault entry block
`timescale 1ns/10ps
`default_nettype none
`include "mmuf_defines.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected t=%0t got %h want %h", $time, a, b); end end

module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tlb_load = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd;
  logic err;
  wire logic [31:0] prdata, acc_paddr, fault_target, acc_vaddr, acc_pc, acc_branch_pc, gr15;
  wire logic [2:0] acc_op;
  wire logic pready, pslverr, acc_valid, acc_delay_slot, acc_done, acc_fault, refetch_req;
  int fail_count = 0, checked = 0;
  logic [31:0] ad [6];
  logic [31:0] ex [6];

  // ==========================================================
  // Design, pipeline model, clock
  mmuf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .acc_valid(acc_valid), .acc_op(acc_op), .acc_vaddr(acc_vaddr),
    .acc_pc(acc_pc), .acc_delay_slot(acc_delay_slot), .acc_branch_pc(acc_branch_pc),
    .gr15(gr15), .acc_done(acc_done), .acc_fault(acc_fault), .acc_paddr(acc_paddr),
    .fault_target(fault_target), .tlb_load(tlb_load), .refetch_req(refetch_req));
  mmuf_core_model core (.pclk(pclk), .acc_done(acc_done), .acc_fault(acc_fault),
    .acc_valid(acc_valid), .acc_op(acc_op), .acc_vaddr(acc_vaddr), .acc_pc(acc_pc),
    .acc_branch_pc(acc_branch_pc), .gr15(gr15), .acc_delay_slot(acc_delay_slot));
  initial begin
    forever #25 pclk = ~pclk;
  end

  // ==========================================================
  // Verdict and bus tasks
  task automatic results();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Request held until pready is seen; a hang ends the run
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20) begin fail_count++; results(); end
  endtask
  // Entry index goes through the counter field, then the load strobe
  task automatic load_entry(input int i, input logic [31:0] va, input logic [1:0] pr,
                            input logic d);
    // Boundary field at its top, so the counter never lies above it
    apb(1, `MMUF_ADDR_MMU_CTRL, i << 10 | 32'h00fc_0000);
    apb(1, `MMUF_ADDR_PAGE_HIGH, {va[31:10], 10'h000});
    apb(1, `MMUF_ADDR_PAGE_LOW, (32'h0abc + i) << 10 | 32'h100 | pr << 5 | d << 2);
    @(posedge pclk);
    tlb_load <= 1;
    @(posedge pclk);
    tlb_load <= 0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic fault(input logic [2:0] op, input logic [31:0] va, input logic slot,
                       input logic [11:0] ev, input logic [31:0] off);
    // Low status bits set so the saved copy is not trivially zero
    apb(1, `MMUF_ADDR_STATUS, 32'h0000_00f0);
    core.access(op, va, slot);
    `CHK(core.seen, 1'b1)
    `CHK(fault_target, 32'h0001_0000 + off)
    apb(0, `MMUF_ADDR_EVENT, 0);
    `CHK(rd[11:0], ev)
    ad = '{`MMUF_ADDR_FAULT_ADDR, `MMUF_ADDR_PAGE_HIGH, `MMUF_ADDR_SAVED_PC,
           `MMUF_ADDR_SAVED_STATUS, `MMUF_ADDR_SAVED_STACK, `MMUF_ADDR_STATUS};
    ex = '{va, {va[31:10], 10'h000}, slot ? va + 32'h0c : va + 32'h10, 32'h0000_00f0,
           ~va, 32'h7000_00f0};
    for (int k = 0; k < 6; k++) begin
      apb(0, ad[k], 0);
      `CHK(rd, ex[k])
    end
  endtask
  task automatic hit(input logic [2:0] op, input int i, input logic [31:0] va);
    apb(1, `MMUF_ADDR_STATUS, 0);
    core.access(op, va, 0);
    `CHK(core.seen, 1'b0)
    `CHK(acc_paddr, {3'b000, 19'h0abc + 19'(i), va[9:0]})
  endtask
  task automatic t_faults();
    for (int op = 0; op < 6; op++)
      fault(op, 32'h0040_0000 | op << 12, op[0], (op == 1 || op > 3) ?
            `MMUF_EVT_MISS_WR : `MMUF_EVT_MISS_RD, `MMUF_VEC_MISS);
    // Handler order: dirty set in the page entry before the reload
    load_entry(0, 32'h0080_0000, 2'b10, 0);
    load_entry(1, 32'h0081_0000, 2'b00, 0);
    load_entry(2, 32'h0082_0000, 2'b11, 0);
    load_entry(3, 32'h0083_0000, 2'b11, 1);
    hit(`MMUF_OP_LOAD, 0, 32'h0080_0123);
    hit(`MMUF_OP_PURGE, 0, 32'h0080_02a4);
    hit(`MMUF_OP_STORE, 3, 32'h0083_0123);
    // Privileged mode reaches a page closed to user code
    apb(1, `MMUF_ADDR_STATUS, 32'h4000_0000);
    core.access(`MMUF_OP_LOAD, 32'h0081_0123, 0);
    `CHK(core.seen, 1'b0)
    fault(`MMUF_OP_STORE, 32'h0080_0040, 0, `MMUF_EVT_PROT_WR, `MMUF_VEC_GENERAL);
    fault(`MMUF_OP_LOAD, 32'h0081_0040, 1, `MMUF_EVT_PROT_RD, `MMUF_VEC_GENERAL);
    fault(`MMUF_OP_STORE, 32'h0081_0080, 0, `MMUF_EVT_PROT_WR, `MMUF_VEC_GENERAL);
    fault(`MMUF_OP_ALLOC, 32'h0082_0010, 0, `MMUF_EVT_FIRST_WR, `MMUF_VEC_GENERAL);
    $display("faults done");
  endtask
  // Block bit left set by the last fault: registers must hold
  task automatic t_mask();
    core.access(`MMUF_OP_STORE, 32'h0090_0000, 0);
    `CHK(core.seen, 1'b1)
    apb(0, `MMUF_ADDR_FAULT_ADDR, 0);
    `CHK(rd, 32'h0082_0010)
    $display("mask done");
  endtask
  task automatic t_reset();
    apb(0, `MMUF_ADDR_STATUS, 0);
    `CHK(rd, `MMUF_STAT_RESET)
    apb(0, `MMUF_ADDR_REFETCH_CTRL, 0);
    `CHK(rd, `MMUF_REFETCH_RESET)
    `CHK(refetch_req, 1'b0)
    $display("reset done");
  endtask
  // Mapped buffer reached in privileged mode by longword moves only
  task automatic t_map();
    apb(1, 32'hf200_0100, 32'habcd_e5a7);
    apb(1, 32'hf200_0200, 32'h1234_4012);
    apb(0, 32'hf200_0100, 0);
    `CHK(rd & 32'hffff_fdff, 32'habcd_e5a7)
    apb(0, 32'hf200_0200, 0);
    `CHK(rd & 32'hffff_fdff, 32'h1234_4012)
    apb(0, 32'hff00_0100, 0);
    `CHK(err, 1'b1)
    apb(1, 32'hf200_0102, 0);
    `CHK(err, 1'b1)
    $display("map done");
  endtask
  // Leaving the mapped region relies on the refetch after a control write
  task automatic t_refetch();
    apb(1, `MMUF_ADDR_MMU_CTRL, 0);
    @(posedge pclk);
    `CHK(refetch_req, 1'b1)
    apb(1, `MMUF_ADDR_REFETCH_CTRL, 1);
    apb(1, `MMUF_ADDR_MMU_CTRL, 0);
    @(posedge pclk);
    `CHK(refetch_req, 1'b0)
    $display("refetch done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset();
    apb(1, `MMUF_ADDR_VECTOR_BASE, 32'h0001_0000);
    t_faults();
    t_mask();
    t_map();
    t_refetch();
    results();
  end
endmodule
`default_nettype wire
